/* File: shared/dvi_pkg.sv */
// Package: constants for the interrupt vectoring and prioritisation block
package dvi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_SLOTS = 14;
  localparam int IDX_W = 4;
  localparam int VEC_W = 7;
  localparam int LVL_W = 5;
  localparam int SWN_W = 5;
  localparam int SEL_W = 4;
  localparam int PIN_W = 6;
  localparam int VEC_SHIFT = 2;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PENDING_FLAGS = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_DMA_CTRL = 8'h54;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_SLOTS-1:0] MASK_RST = 14'h0000;
  localparam logic [DATA_W-1:0] DMA_CTRL_RST = 16'h0000;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h3F;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int BIT_EXT0 = 0;
  localparam int BIT_EXT1 = 1;
  localparam int BIT_EXT2 = 2;
  localparam int BIT_TIMER0 = 3;
  localparam int BIT_SER0_RX = 4;
  localparam int BIT_SER0_TX = 5;
  localparam int BIT_SHARED_DMA0 = 6;
  localparam int BIT_SHARED_DMA1 = 7;
  localparam int BIT_EXT3 = 8;
  localparam int BIT_HOST = 9;
  localparam int BIT_SHARED_DMA2 = 10;
  localparam int BIT_SHARED_DMA3 = 11;
  localparam int BIT_DMA4 = 12;
  localparam int BIT_DMA5 = 13;

  // Pin vector positions
  localparam int PIN_NMI = 4;
  localparam int PIN_RST = 5;

  // Source select bits in the DMA priority and enable control register
  localparam int SEL_SLOT6 = 0;
  localparam int SEL_SLOT7 = 1;
  localparam int SEL_SLOT10 = 2;
  localparam int SEL_SLOT11 = 3;

  // ----------------------------------------------------------------
  // Vectors and priority levels
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_RESET = 7'h00;
  localparam logic [VEC_W-1:0] VEC_NMI = 7'h04;
  localparam logic [VEC_W-1:0] VEC_SW_FIRST = 7'h08;
  localparam logic [VEC_W-1:0] VEC_MASKABLE_BASE = 7'h40;
  localparam logic [VEC_W-1:0] VEC_RESERVED_LO = 7'h78;
  localparam logic [LVL_W-1:0] LVL_RESET = 5'h01;
  localparam logic [LVL_W-1:0] LVL_NMI = 5'h02;
  localparam logic [LVL_W-1:0] LVL_MASKABLE_BASE = 5'h03;
  localparam logic [SWN_W-1:0] SW_FIRST = 5'h11;
  localparam logic [SWN_W-1:0] SW_LAST = 5'h1E;
  localparam logic [SWN_W-1:0] SW_BIAS = 5'h0F;

  localparam logic [VEC_W-1:0] SLOT_VECTOR [NUM_SLOTS] = '{
    7'h40, 7'h44, 7'h48, 7'h4C, 7'h50, 7'h54, 7'h58,
    7'h5C, 7'h60, 7'h64, 7'h68, 7'h6C, 7'h70, 7'h74};
  localparam logic [LVL_W-1:0] SLOT_LEVEL [NUM_SLOTS] = '{
    5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10};

  // Source of the vector currently presented to the core
  typedef enum logic [3:0] {
    SRC_NONE = 4'b0001,
    SRC_RESET = 4'b0010,
    SRC_NMI = 4'b0100,
    SRC_MASKABLE = 4'b1000
  } dvi_src_e;

endpackage

/* File: rtl/dvi_flag_cell.sv */
// Sticky flag cell: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module dvi_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic flag_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= RESET_VAL;
    end else if (set) begin
      flag_reg <= 1'b1;
    end else if (clr) begin
      flag_reg <= 1'b0;
    end
  end

  assign q = flag_reg;

endmodule
`default_nettype wire

/* File: rtl/dvi_vectoring.sv */
// Interrupt vectoring and prioritisation for the signal processor core
// Functional notes
// RULE_01 - Vectors sit at word offsets from base, four words apart; 78-7F unused.
// RULE_02 - Hardware and software reset vector to 00 at highest priority 1.
// RULE_03 - External request 0 vectors to 40 with priority 3.
// RULE_04 - External request 1 vectors to 44 with priority 4.
// RULE_05 - External request 2 vectors to 48 with priority 5.
// RULE_06 - Timer 0 at 4C/6, serial 0 receive 50/7, transmit 54/8.
// RULE_07 - Slot 58 priority 9 unused unless selected for DMA channel 0.
// RULE_08 - Slot 5C priority 10 is timer 1, or DMA channel 1 when selected.
// RULE_09 - External request 3 at 60/11; host port at 64/12.
// RULE_10 - Slot 68 priority 13 is serial 1 receive, or DMA channel 2.
// RULE_11 - Slot 6C (108) is serial 1 transmit, or DMA channel 3.
// RULE_12 - DMA channel 4 has dedicated slot 70, priority 15.
// RULE_13 - DMA channel 5 has dedicated slot 74, lowest priority 16.
// RULE_14 - Flags and mask share layout; 15-14 reserved, 13-10 DMA/serial 1.
// RULE_15 - Bits 9-0: host, ext 3, timer1/DMA1, DMA0, serial 0, timer 0, ext 2-0.
// RULE_16 - Shared bits flag and mask whichever source the DMA control selects.
// RULE_17 - Shared-slot selection lives in the DMA control register at 54h.
// RULE_18 - NMI at 04 priority 2; software slots 17-30 at 08-3C, unarbitrated.
// RULE_19 - Smallest priority number wins; masked maskable sources are ignored.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dvi_vectoring
  import dvi_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [3:0] external_request_n,
  input wire logic nmi_n,
  input wire logic reset_input_n,
  input wire logic soft_reset_trap,
  input wire logic timer0_event,
  input wire logic timer1_event,
  input wire logic serial0_rx_event,
  input wire logic serial0_tx_event,
  input wire logic serial1_rx_event,
  input wire logic serial1_tx_event,
  input wire logic host_port_event,
  input wire logic dma_channel0_event,
  input wire logic dma_channel1_event,
  input wire logic dma_channel2_event,
  input wire logic dma_channel3_event,
  input wire logic dma_channel4_event,
  input wire logic dma_channel5_event,
  input wire logic core_ack,
  input wire logic sw_trap_valid,
  input wire logic [SWN_W-1:0] sw_trap_num,
  output logic irq_out,
  output logic [VEC_W-1:0] int_vector,
  output logic [LVL_W-1:0] int_level,
  output logic [VEC_W-1:0] sw_vector,
  output logic sw_vector_valid
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [PIN_W-1:0] pin_prev_reg;
  logic [PIN_W-1:0] pin_fell;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
      pin_prev_reg <= PIN_IDLE;
    end else begin
      pin_meta_reg <= {reset_input_n, nmi_n, external_request_n};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_fell = pin_prev_reg & ~pin_sync_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] mask_reg;
  logic [DATA_W-1:0] dma_ctrl_reg;
  logic [NUM_SLOTS-1:0] flags;
  logic [SEL_W-1:0] sel;
  logic wr_mask;
  logic wr_flags;
  logic wr_dma;

  assign wr_mask = reg_wr && (reg_addr == ADDR_ENABLE_MASK);
  assign wr_flags = reg_wr && (reg_addr == ADDR_PENDING_FLAGS);
  assign wr_dma = reg_wr && (reg_addr == ADDR_DMA_CTRL);
  assign sel = dma_ctrl_reg[SEL_W-1:0];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= reg_wdata[NUM_SLOTS-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dma_ctrl_reg <= DMA_CTRL_RST;
    end else if (wr_dma) begin
      dma_ctrl_reg <= reg_wdata; // RULE_17
    end
  end

  logic [DATA_W-1:0] rdata_reg;

  // Reserved bits 15-14 read as zero; unmapped addresses read as zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ENABLE_MASK: rdata_reg <= DATA_W'(mask_reg); // RULE_14
        ADDR_PENDING_FLAGS: rdata_reg <= DATA_W'(flags); // RULE_15
        ADDR_DMA_CTRL: rdata_reg <= dma_ctrl_reg;
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Source routing onto flag bits
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] src_set;

  always_comb begin
    src_set = '0;
    src_set[BIT_EXT0] = pin_fell[BIT_EXT0]; // RULE_03
    src_set[BIT_EXT1] = pin_fell[BIT_EXT1]; // RULE_04
    src_set[BIT_EXT2] = pin_fell[BIT_EXT2]; // RULE_05
    src_set[BIT_TIMER0] = timer0_event; // RULE_06
    src_set[BIT_SER0_RX] = serial0_rx_event; // RULE_06
    src_set[BIT_SER0_TX] = serial0_tx_event; // RULE_06
    src_set[BIT_SHARED_DMA0] = sel[SEL_SLOT6] & dma_channel0_event; // RULE_07
    src_set[BIT_SHARED_DMA1] = sel[SEL_SLOT7] ? dma_channel1_event : timer1_event; // RULE_08
    src_set[BIT_EXT3] = pin_fell[3]; // RULE_09
    src_set[BIT_HOST] = host_port_event; // RULE_09
    src_set[BIT_SHARED_DMA2] = sel[SEL_SLOT10] ? dma_channel2_event : serial1_rx_event; // RULE_10
    src_set[BIT_SHARED_DMA3] = sel[SEL_SLOT11] ? dma_channel3_event : serial1_tx_event; // RULE_11
    src_set[BIT_DMA4] = dma_channel4_event; // RULE_12
    src_set[BIT_DMA5] = dma_channel5_event; // RULE_13
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  dvi_src_e src_reg;
  logic [IDX_W-1:0] served_idx_reg;
  logic ack_mask;
  logic [NUM_SLOTS-1:0] flag_clr;
  logic reset_pend;
  logic nmi_pend;
  logic reset_set;

  assign ack_mask = core_ack && (src_reg == SRC_MASKABLE);
  assign reset_set = !pin_sync_reg[PIN_RST] || soft_reset_trap; // RULE_02

  // Each bit is cleared by a written one or by the core taking its vector
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_flag
      assign flag_clr[gi] = (wr_flags && reg_wdata[gi]) ||
                            (ack_mask && (served_idx_reg == IDX_W'(gi)));
      dvi_flag_cell #(.RESET_VAL(1'b0)) u_flag (
        .core_clk(core_clk),
        .nrst(nrst),
        .set(src_set[gi]), // RULE_16
        .clr(flag_clr[gi]),
        .q(flags[gi])
      );
    end
  endgenerate

  dvi_flag_cell #(.RESET_VAL(1'b1)) u_reset_pend (
    .core_clk(core_clk),
    .nrst(nrst),
    .set(reset_set),
    .clr(core_ack && (src_reg == SRC_RESET)),
    .q(reset_pend)
  );

  dvi_flag_cell #(.RESET_VAL(1'b0)) u_nmi_pend (
    .core_clk(core_clk),
    .nrst(nrst),
    .set(pin_fell[PIN_NMI]),
    .clr(core_ack && (src_reg == SRC_NMI)),
    .q(nmi_pend)
  );

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] enabled;
  logic win_found;
  logic [IDX_W-1:0] win_idx;

  assign enabled = flags & mask_reg; // RULE_19

  // Lowest bit carries the smallest priority number
  always_comb begin
    win_found = 1'b0;
    win_idx = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (enabled[i]) begin
        win_found = 1'b1;
        win_idx = IDX_W'(i); // RULE_19
      end
    end
  end

  logic [VEC_W-1:0] vector_reg;
  logic [LVL_W-1:0] level_reg;
  logic irq_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_reg <= SRC_NONE;
      served_idx_reg <= '0;
      vector_reg <= VEC_RESET;
      level_reg <= LVL_RESET;
    end else if (reset_pend) begin
      src_reg <= SRC_RESET;
      vector_reg <= VEC_RESET; // RULE_02
      level_reg <= LVL_RESET;
    end else if (nmi_pend) begin
      src_reg <= SRC_NMI;
      vector_reg <= VEC_NMI; // RULE_18
      level_reg <= LVL_NMI;
    end else if (win_found) begin
      src_reg <= SRC_MASKABLE;
      served_idx_reg <= win_idx;
      vector_reg <= SLOT_VECTOR[win_idx]; // RULE_01
      level_reg <= SLOT_LEVEL[win_idx];
    end else begin
      src_reg <= SRC_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= reset_pend || nmi_pend || win_found;
    end
  end

  // ----------------------------------------------------------------
  // Software trap vectors
  // ----------------------------------------------------------------
  logic [VEC_W-1:0] sw_vector_reg;
  logic sw_valid_reg;
  logic sw_in_range;

  assign sw_in_range = sw_trap_valid && (sw_trap_num >= SW_FIRST) && (sw_trap_num <= SW_LAST);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sw_vector_reg <= VEC_SW_FIRST;
      sw_valid_reg <= 1'b0;
    end else begin
      sw_valid_reg <= sw_in_range;
      if (sw_in_range) begin
        sw_vector_reg <= VEC_SW_FIRST +
                         (VEC_W'(sw_trap_num - SW_FIRST) << VEC_SHIFT); // RULE_18
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq_out = irq_reg;
  assign int_vector = vector_reg;
  assign int_level = level_reg;
  assign sw_vector = sw_vector_reg;
  assign sw_vector_valid = sw_valid_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic no_urgent;
  assign no_urgent = !reset_pend && !nmi_pend;

  sequence s_ext0_fall;
    pin_prev_reg[BIT_EXT0] && !pin_sync_reg[BIT_EXT0];
  endsequence

  sequence s_ext0_enabled;
    s_ext0_fall ##1 (mask_reg[BIT_EXT0] && no_urgent);
  endsequence

  sequence s_read_flags;
    reg_rd && (reg_addr == ADDR_PENDING_FLAGS);
  endsequence

  a_vector_spacing: assert property ( // RULE_01
    (src_reg == SRC_MASKABLE) |-> (vector_reg < VEC_RESERVED_LO) &&
      (vector_reg == VEC_MASKABLE_BASE + (VEC_W'(level_reg - LVL_MASKABLE_BASE) << VEC_SHIFT)))
    else $error("maskable vector not four words per level");

  a_reset_first: assert property ( // RULE_02
    reset_pend |=> (vector_reg == VEC_RESET) && (level_reg == LVL_RESET) && irq_reg)
    else $error("pending reset not presented at offset 00");

  a_ext0_vector: assert property ( // RULE_03
    s_ext0_enabled |=> (vector_reg == SLOT_VECTOR[BIT_EXT0]) && (level_reg == LVL_MASKABLE_BASE))
    else $error("external request 0 not vectored to slot 40");

  a_ext1_vector: assert property ( // RULE_04
    (enabled[BIT_EXT1] && !enabled[BIT_EXT0] && no_urgent) |=>
      (vector_reg == 7'h44) && (level_reg == 5'h04))
    else $error("external request 1 not vectored to slot 44");

  a_ext2_vector: assert property ( // RULE_05
    (enabled[2:0] == 3'h4 && no_urgent) |=> (vector_reg == 7'h48) && (level_reg == 5'h05))
    else $error("external request 2 not vectored to slot 48");

  a_slot6_unused: assert property ( // RULE_07
    (!sel[SEL_SLOT6] && !flags[BIT_SHARED_DMA0]) |=> !flags[BIT_SHARED_DMA0])
    else $error("unselected slot 58 became pending");

  a_slot7_source: assert property ( // RULE_08
    (!sel[SEL_SLOT7] && timer1_event) |=> flags[BIT_SHARED_DMA1])
    else $error("timer 1 event lost on slot 5C");

  a_slot10_source: assert property ( // RULE_10
    (sel[SEL_SLOT10] && dma_channel2_event) |=> flags[BIT_SHARED_DMA2])
    else $error("DMA channel 2 event lost on slot 68");

  a_slot11_source: assert property ( // RULE_11
    (sel[SEL_SLOT11] && dma_channel3_event) |=> flags[BIT_SHARED_DMA3])
    else $error("DMA channel 3 event lost on slot 6C");

  a_dma5_lowest: assert property ( // RULE_13
    (enabled == (NUM_SLOTS'(1) << BIT_DMA5) && no_urgent) |=>
      (vector_reg == 7'h74) && (level_reg == 5'h10))
    else $error("DMA channel 5 not vectored to slot 74 at level 16");

  a_reserved_zero: assert property ( // RULE_14
    s_read_flags |=> (rdata_reg[DATA_W-1:NUM_SLOTS] == '0) &&
      (rdata_reg[NUM_SLOTS-1:0] == $past(flags)))
    else $error("flag read returned wrong bits");

  a_set_wins: assert property ( // RULE_16
    (src_set[BIT_HOST] && flag_clr[BIT_HOST]) |=> flags[BIT_HOST])
    else $error("event lost against simultaneous clear");

  a_sw_trap_map: assert property ( // RULE_18
    sw_in_range |=> sw_valid_reg &&
      (sw_vector_reg == ((VEC_W'($past(sw_trap_num)) - VEC_W'(SW_BIAS)) << VEC_SHIFT)))
    else $error("software trap vector wrong");

  a_masked_quiet: assert property ( // RULE_19
    (no_urgent && ((flags & mask_reg) == '0)) |=> !irq_reg)
    else $error("interrupt raised with only masked sources");

endmodule
`default_nettype wire

/* File: bench/dvi_core_model.sv */
// Core sequencer model: takes presented vectors and records what it took
`timescale 1ns/1ps
`default_nettype none
module dvi_core_model
  import dvi_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [3:0] dly,
  input wire logic irq_out,
  input wire logic [VEC_W-1:0] int_vector,
  input wire logic [LVL_W-1:0] int_level,
  output logic core_ack,
  output logic [VEC_W-1:0] got_vec,
  output logic [LVL_W-1:0] got_lvl,
  output logic [15:0] got_cnt
);
  logic [3:0] hold_reg;
  logic [1:0] cool_reg;
  // Cool-down lets the next arbitration settle before the next look
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      core_ack <= 1'b0;
      got_vec <= '0;
      got_lvl <= '0;
      got_cnt <= '0;
      hold_reg <= '0;
      cool_reg <= '0;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      got_vec <= int_vector;
      got_lvl <= int_level;
      got_cnt <= got_cnt + 16'h0001;
      cool_reg <= 2'h3;
    end else if (cool_reg != 2'h0) begin
      cool_reg <= cool_reg - 2'h1;
    end else if (go && irq_out) begin
      if (hold_reg >= dly) begin
        core_ack <= 1'b1;
        hold_reg <= '0;
      end else begin
        hold_reg <= hold_reg + 4'h1;
      end
    end else begin
      hold_reg <= '0;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_dvi_vectoring.sv */
// Testbench for the interrupt vectoring block
`timescale 1ns/1ps
`default_nettype none
module tb_dvi_vectoring
  import dvi_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] ext_n = 4'hF;
  logic nmi_n = 1'b1;
  logic soft_rst = 1'b0;
  logic rst_pin_n = 1'b1;
  logic [13:0] pk = '0;
  logic [5:0] dk = '0;
  logic sw_v = 1'b0;
  logic [SWN_W-1:0] sw_n = '0;
  logic go = 1'b0;
  logic [3:0] dly = 4'h0;
  logic core_ack, irq_out, sw_vector_valid;
  logic [VEC_W-1:0] int_vector, sw_vector, got_vec;
  logic [LVL_W-1:0] int_level, got_lvl;
  logic [15:0] got_cnt;
  logic [15:0] d;
  logic [15:0] c0;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  dvi_vectoring i_dvi_vectoring (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_request_n(ext_n), .nmi_n(nmi_n), .reset_input_n(rst_pin_n),
    .soft_reset_trap(soft_rst), .timer0_event(pk[3]), .timer1_event(pk[7]),
    .serial0_rx_event(pk[4]), .serial0_tx_event(pk[5]), .serial1_rx_event(pk[10]),
    .serial1_tx_event(pk[11]), .host_port_event(pk[9]), .dma_channel0_event(dk[0]),
    .dma_channel1_event(dk[1]), .dma_channel2_event(dk[2]), .dma_channel3_event(dk[3]),
    .dma_channel4_event(dk[4]), .dma_channel5_event(dk[5]), .core_ack(core_ack),
    .sw_trap_valid(sw_v), .sw_trap_num(sw_n), .irq_out(irq_out),
    .int_vector(int_vector), .int_level(int_level), .sw_vector(sw_vector),
    .sw_vector_valid(sw_vector_valid));

  dvi_core_model i_dvi_core_model (.core_clk(core_clk), .nrst(nrst), .go(go), .dly(dly),
    .irq_out(irq_out), .int_vector(int_vector), .int_level(int_level),
    .core_ack(core_ack), .got_vec(got_vec), .got_lvl(got_lvl), .got_cnt(got_cnt));

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Pins are held low for a few cycles so the synchroniser sees them
  task automatic fire(input int i, input bit dma);
    @(posedge core_clk);
    if (dma) dk[(i < 8) ? i - 6 : i - 8] <= 1'b1;
    else if (i < 3 || i == 8) ext_n[(i < 3) ? i : 3] <= 1'b0;
    else pk[i] <= 1'b1;
    @(posedge core_clk);
    dk <= '0;
    pk <= '0;
    repeat (3) @(posedge core_clk);
    ext_n <= 4'hF;
  endtask

  task automatic wait_ack(input logic [15:0] n, input logic [VEC_W-1:0] v,
                          input logic [LVL_W-1:0] l);
    int k;
    k = 0;
    while (got_cnt !== n && k < 40) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk(got_cnt, n);
    chk(16'(got_vec), 16'(v));
    chk(16'(got_lvl), 16'(l));
  endtask

  task automatic hit(input int i, input bit dma);
    c0 = got_cnt;
    fire(i, dma);
    wait_ack(c0 + 16'h1, 7'h40 + 7'(4 * i), 5'h03 + 5'(i));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    repeat (2) @(posedge core_clk);
    #1;
    chk({irq_out, 8'h00, int_vector}, 16'h8000);
    chk(16'(int_level), 16'h0001);
    rd(ADDR_ENABLE_MASK);
    chk(d, 16'h0000);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0000);
    rd(ADDR_DMA_CTRL);
    chk(d, 16'h0000);
    go <= 1'b1;
    wait_ack(16'h1, 7'h00, 5'h01);
    repeat (4) @(posedge core_clk);
    #1;
    chk(16'(irq_out), 16'h0000);
  endtask

  task automatic t_regs;
    wr(ADDR_ENABLE_MASK, 16'hFFFF);
    rd(ADDR_ENABLE_MASK);
    chk(d, 16'h3FFF);
    wr(ADDR_DMA_CTRL, 16'hA5C3);
    rd(ADDR_DMA_CTRL);
    chk(d, 16'hA5C3);
    wr(8'h02, 16'hFFFF);
    rd(8'h02);
    chk(d, 16'h0000);
    wr(ADDR_DMA_CTRL, 16'h0000);
  endtask

  task automatic t_slots(input bit sel);
    wr(ADDR_DMA_CTRL, sel ? 16'h000F : 16'h0000);
    for (int i = 0; i < 14; i++) begin
      if (sel || i != 6) begin
        wr(ADDR_ENABLE_MASK, 16'h0001 << i);
        hit(i, (i > 11) || (sel && (i == 6 || i == 7 || i == 10 || i == 11)));
      end
    end
  endtask

  task automatic t_shared;
    go <= 1'b0;
    wr(ADDR_DMA_CTRL, 16'h0000);
    foreach (d[i]) if (i == 6 || i == 7 || i == 10 || i == 11) fire(i, 1'b1);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0000);
    wr(ADDR_DMA_CTRL, 16'h000F);
    foreach (d[i]) if (i == 7 || i == 10 || i == 11) fire(i, 1'b0);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0000);
    wr(ADDR_DMA_CTRL, 16'h0000);
    go <= 1'b1;
  endtask

  task automatic t_mask;
    wr(ADDR_ENABLE_MASK, 16'h0000);
    fire(3, 1'b0);
    repeat (4) @(posedge core_clk);
    #1;
    chk(16'(irq_out), 16'h0000);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0008);
    c0 = got_cnt;
    wr(ADDR_ENABLE_MASK, 16'h0008);
    wait_ack(c0 + 16'h1, 7'h4C, 5'h06);
    fire(4, 1'b0);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0010);
    wr(ADDR_PENDING_FLAGS, 16'h0010);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0000);
    // Host event and its write-one-clear in one cycle: the event must survive
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_PENDING_FLAGS;
    reg_wdata <= 16'h0200;
    pk[9] <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    pk <= '0;
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0200);
    wr(ADDR_PENDING_FLAGS, 16'h0200);
    rd(ADDR_PENDING_FLAGS);
    chk(d, 16'h0000);
  endtask

  task automatic t_prio;
    go <= 1'b0;
    dly <= 4'h2;
    wr(ADDR_ENABLE_MASK, 16'h3FFF);
    c0 = got_cnt;
    @(posedge core_clk);
    nmi_n <= 1'b0;
    pk <= 14'h0028;
    dk <= 6'h20;
    @(posedge core_clk);
    pk <= '0;
    dk <= '0;
    repeat (4) @(posedge core_clk);
    nmi_n <= 1'b1;
    go <= 1'b1;
    wait_ack(c0 + 16'h1, 7'h04, 5'h02);
    wait_ack(c0 + 16'h2, 7'h4C, 5'h06);
    wait_ack(c0 + 16'h3, 7'h54, 5'h08);
    wait_ack(c0 + 16'h4, 7'h74, 5'h10);
    dly <= 4'h0;
  endtask

  task automatic t_soft;
    c0 = got_cnt;
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    wait_ack(c0 + 16'h1, 7'h00, 5'h01);
    // Hardware reset pin held low, core kept away until the pin is high again
    go <= 1'b0;
    c0 = got_cnt;
    @(posedge core_clk);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_pin_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk({irq_out, 8'h00, int_vector}, 16'h8000);
    go <= 1'b1;
    wait_ack(c0 + 16'h1, 7'h00, 5'h01);
  endtask

  task automatic t_trap;
    for (int n = 16; n < 32; n++) begin
      @(posedge core_clk);
      sw_v <= 1'b1;
      sw_n <= 5'(n);
      @(posedge core_clk);
      sw_v <= 1'b0;
      #1;
      chk(16'(sw_vector_valid), 16'(n > 16 && n < 31));
      if (n > 16 && n < 31) chk(16'(sw_vector), 16'(8 + 4 * (n - 17)));
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_slots(1'b0);
    t_slots(1'b1);
    t_shared();
    t_mask();
    t_prio();
    t_soft();
    t_trap();
    summarize();
  end
endmodule
`default_nettype wire
